// File: core/pcihb_defines.vh
// constants for the pci host bridge arbiter block
`ifndef PCIHB_DEFINES_VH
`define PCIHB_DEFINES_VH
`define PCIHB_IRQ_LINE_PIN_ADDR 32'h0F000D3C
`define PCIHB_RETRY_ARB_ADDR 32'h0F000D40
`define PCIHB_WIN2_BASE_ADDR 32'h0F000D18
`define PCIHB_WIN2_CTRL_ADDR 32'h0F000D60
`define PCIHB_STATUS_ADDR 32'h0F000D64
`define PCIHB_FAIL_ADDR_ADDR 32'h0F000D68
`define PCIHB_IRQ_PIN_CODE 8'h01
`define PCIHB_WIN2_BASE_RST 32'h00000008
`define PCIHB_WIN2_HI 31
`define PCIHB_WIN2_LO 21
`define PCIHB_WIN2_MSK_HI 27
`define PCIHB_TAKEAWAY_BIT 26
`define PCIHB_PRIO_HI 25
`define PCIHB_PRIO_LO 24
`define PCIHB_RETRY_HI 15
`define PCIHB_RETRY_LO 8
`define PCIHB_PRIO_FAIR 2'h0
`define PCIHB_PRIO_EXT0 2'h1
`define PCIHB_PRIO_BRIDGE 2'h2
`define PCIHB_FRAME_CLKS 5'h10
`define PCIHB_BRIDGE_IDX 2'h3
`define PCIHB_RESP_OKAY 2'h0
`define PCIHB_RESP_SLVERR 2'h2
`endif

// File: core/pcihb_sync.v
// two-flop synchroniser for inputs from outside the mclk domain
`timescale 1ns/100ps
module pcihb_sync #(
  parameter WIDTH = 1
) (
  input wire mclk,
  input wire rstn,
  input wire ce,
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end
    else if (ce)
    begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule

// File: core/pcihb_bridge.v
// pci host bridge: config registers, bus arbiter and transaction transfer
// Operation
// - window2 base bits 27:21 ANDed with mask
// - interrupt pin code fixed 0x01 read-only
// - interrupt line byte is a software memo
// - reserved bits read zero, write zero
// - retry limit byte, zero means unlimited
// - bit 26 enables take-away grant
// - bits 25:24 select arbiter priority mode
// - arbitrate bridge plus three external requests
// - priority re-evaluated and rotated every pci clock
// - fair mode spreads priority over masters 0-3
// - bridge-priority mode favours bridge request
// - agent-0 mode favours external agent 0
// - take-away moves grant to higher priority
// - idle bus parks on last transaction master
// - withdraw external grant after 16 frameless clocks
// - withdrawn with no requester: grant bridge
// - pci read: latch address, retry, read internally
// - delayed read pending: retry every window access
// - matching retried read gets fetched data
// - pci write posted then written internally
// - internal read waits slave ready for pci data
// - internal write posted then written to pci
// - retry limit reached: discard, flag, record address
`timescale 1ns/100ps
`include "pcihb_defines.vh"
module pcihb_bridge (
  input wire mclk,
  input wire rstn,
  input wire ce,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire pciClk,
  input wire [2:0] extRequestN,
  output reg [2:0] extGrantN,
  output reg bridgeGrant,
  input wire frameN,
  input wire tgtValid,
  input wire tgtWrite,
  input wire [31:0] tgtAddr,
  input wire [31:0] tgtWdata,
  output reg tgtRetry,
  output reg tgtAck,
  output reg [31:0] tgtRdata,
  output reg imReq,
  output reg imWrite,
  output reg [31:0] imAddr,
  output reg [31:0] imWdata,
  input wire imAck,
  input wire [31:0] imRdata,
  input wire isReq,
  input wire isWrite,
  input wire [31:0] isAddr,
  input wire [31:0] isWdata,
  output reg isRdy,
  output reg [31:0] isRdata,
  output reg pmStart,
  output reg pmWrite,
  output reg [31:0] pmAddr,
  output reg [31:0] pmWdata,
  input wire pmDone,
  input wire pmRetry,
  input wire [31:0] pmRdata
);
  localparam T_IDLE = 2'h0;
  localparam T_RDPEND = 2'h1;
  localparam T_RDREADY = 2'h2;
  localparam T_WRPOST = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  wire [7:0] pinSync;
  reg pciPrev_q;
  reg tgtPrev_q;
  reg donePrev_q;
  reg retryPrev_q;

  pcihb_sync #(.WIDTH(8)) pinSyncInst (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .asyncIn({pmRetry, pmDone, tgtValid, ~frameN, ~extRequestN, pciClk}),
    .syncOut(pinSync)
  );

  wire pciRise = pinSync[0] & ~pciPrev_q;
  wire [2:0] extReq = pinSync[3:1]; // inverted at entry so reset reads as idle
  wire frameOn = pinSync[4];
  wire tgtRise = pinSync[5] & ~tgtPrev_q;
  wire tgtFall = ~pinSync[5] & tgtPrev_q;
  wire doneRise = pinSync[6] & ~donePrev_q;
  wire retryRise = pinSync[7] & ~retryPrev_q;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] irqLine_q;
  reg [31:0] win2Base_q;
  reg [6:0] winMask_q;
  reg takeaway_q;
  reg [1:0] prioSel_q;
  reg [7:0] retryLimit_q;
  reg retryReached_q;
  reg [31:0] failAddr_q;
  reg [1:0] tgtState_q;
  reg pmPend_q;

  reg awHave_q;
  reg wHave_q;
  reg [31:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  wire [31:0] wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  wire doWrite = awHave_q & wHave_q & ~s_axi_bvalid;
  wire [31:0] maskedData = wData_q & wMask;
  wire retryFail;

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 32'h00000000;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PCIHB_RESP_OKAY;
      irqLine_q <= 8'h00;
      win2Base_q <= `PCIHB_WIN2_BASE_RST;
      winMask_q <= 7'h00;
      takeaway_q <= 1'b0;
      prioSel_q <= `PCIHB_PRIO_FAIR;
      retryLimit_q <= 8'h00;
      retryReached_q <= 1'b0;
    end
    else if (ce)
    begin
      s_axi_awready <= ~awHave_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~wHave_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (retryFail)
        retryReached_q <= 1'b1;
      if (doWrite)
      begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `PCIHB_RESP_OKAY;
        case (awAddr_q)
          `PCIHB_IRQ_LINE_PIN_ADDR:
          begin
            if (wStrb_q[0])
              irqLine_q <= wData_q[7:0];
          end
          `PCIHB_RETRY_ARB_ADDR:
          begin
            if (wStrb_q[1])
              retryLimit_q <= wData_q[`PCIHB_RETRY_HI:`PCIHB_RETRY_LO];
            if (wStrb_q[3])
            begin
              takeaway_q <= wData_q[`PCIHB_TAKEAWAY_BIT];
              prioSel_q <= wData_q[`PCIHB_PRIO_HI:`PCIHB_PRIO_LO];
            end
          end
          `PCIHB_WIN2_BASE_ADDR:
          begin
            // size probing reads back zeros in base bits 27:21 whose window mask bit is clear
            win2Base_q[`PCIHB_WIN2_HI:`PCIHB_WIN2_LO] <=
              ((win2Base_q[31:21] & ~wMask[31:21]) | maskedData[31:21]) &
              {4'hF, winMask_q};
          end
          `PCIHB_WIN2_CTRL_ADDR:
          begin
            if (wStrb_q[0])
              winMask_q <= wData_q[6:0];
          end
          `PCIHB_STATUS_ADDR:
          begin
            // a new failure in the same cycle keeps the flag set
            if (wStrb_q[0] && wData_q[0] && !retryFail)
              retryReached_q <= 1'b0;
          end
          `PCIHB_FAIL_ADDR_ADDR:
            s_axi_bresp <= `PCIHB_RESP_OKAY;
          default:
            s_axi_bresp <= `PCIHB_RESP_SLVERR;
        endcase
      end
    end
  end

  // read side; reserved bits are constant zero
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PCIHB_RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `PCIHB_RESP_OKAY;
        case (s_axi_araddr)
          `PCIHB_IRQ_LINE_PIN_ADDR:
            s_axi_rdata <= {16'h0000, `PCIHB_IRQ_PIN_CODE, irqLine_q};
          `PCIHB_RETRY_ARB_ADDR:
            s_axi_rdata <= {5'h00, takeaway_q, prioSel_q, 8'h00, retryLimit_q, 8'h00};
          `PCIHB_WIN2_BASE_ADDR:
            s_axi_rdata <= win2Base_q;
          `PCIHB_WIN2_CTRL_ADDR:
            s_axi_rdata <= {25'h0000000, winMask_q};
          `PCIHB_STATUS_ADDR:
            s_axi_rdata <= {28'h0000000, pmPend_q, tgtState_q, retryReached_q};
          `PCIHB_FAIL_ADDR_ADDR:
            s_axi_rdata <= failAddr_q;
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PCIHB_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbiter: index 0..2 external agents, 3 the bridge
  reg [1:0] gntIdx_q;
  reg [1:0] lastOwner_q;
  reg [1:0] rot_q;
  reg [4:0] frameTimer_q;
  wire [3:0] reqV = {pmPend_q, extReq};

  function [2:0] pickFair;
    input [3:0] vec;
    input [1:0] start;
    integer i;
    reg [1:0] idx;
    begin
      pickFair = 3'h0;
      idx = 2'h0;
      for (i = 3; i >= 0; i = i - 1)
      begin
        idx = start + i[1:0];
        if (vec[idx])
          pickFair = {1'b1, idx};
      end
    end
  endfunction

  reg favValid;
  reg [1:0] favIdx;
  reg [2:0] winner;
  reg [2:0] others;

  always @*
  begin
    favValid = 1'b0;
    favIdx = 2'h0;
    case (prioSel_q)
      `PCIHB_PRIO_EXT0:
      begin
        favValid = reqV[0];
        favIdx = 2'h0;
      end
      `PCIHB_PRIO_BRIDGE:
      begin
        favValid = reqV[3];
        favIdx = `PCIHB_BRIDGE_IDX;
      end
      default:
        favValid = 1'b0;
    endcase
    winner = favValid ? {1'b1, favIdx} : pickFair(reqV, rot_q);
    others = pickFair(reqV & ~(4'h1 << gntIdx_q), rot_q);
  end

  wire gntExt = (gntIdx_q != `PCIHB_BRIDGE_IDX);
  reg [1:0] nextGnt;

  always @*
  begin
    nextGnt = gntIdx_q;
    if (frameOn)
      nextGnt = gntIdx_q;
    else if (gntExt && frameTimer_q == `PCIHB_FRAME_CLKS - 5'h01)
      nextGnt = others[2] ? others[1:0] : `PCIHB_BRIDGE_IDX;
    else if (reqV == 4'h0)
      nextGnt = lastOwner_q;
    else if (!reqV[gntIdx_q])
      nextGnt = winner[1:0];
    else if (takeaway_q && favValid && favIdx != gntIdx_q)
      nextGnt = favIdx;
  end

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pciPrev_q <= 1'b0;
      gntIdx_q <= `PCIHB_BRIDGE_IDX;
      lastOwner_q <= `PCIHB_BRIDGE_IDX;
      rot_q <= 2'h0;
      frameTimer_q <= 5'h00;
      extGrantN <= 3'h7;
      bridgeGrant <= 1'b1;
    end
    else if (ce)
    begin
      pciPrev_q <= pinSync[0];
      if (pciRise)
      begin
        rot_q <= rot_q + 2'h1;
        gntIdx_q <= nextGnt;
        if (frameOn)
          lastOwner_q <= gntIdx_q;
        // timer only runs while an external master holds grant without a frame
        if (frameOn || nextGnt != gntIdx_q || nextGnt == `PCIHB_BRIDGE_IDX)
          frameTimer_q <= 5'h00;
        else
          frameTimer_q <= frameTimer_q + 5'h01;
        extGrantN <= ~(3'h1 << nextGnt) | {3{nextGnt == `PCIHB_BRIDGE_IDX}};
        bridgeGrant <= (nextGnt == `PCIHB_BRIDGE_IDX);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pci target path into the internal bus
  reg [31:0] heldAddr_q;
  wire win2Hit = ((tgtAddr[31:21] ^ win2Base_q[31:21]) & {4'hF, winMask_q}) == 11'h000;

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      tgtPrev_q <= 1'b0;
      tgtState_q <= T_IDLE;
      heldAddr_q <= 32'h00000000;
      tgtRetry <= 1'b0;
      tgtAck <= 1'b0;
      tgtRdata <= 32'h00000000;
      imReq <= 1'b0;
      imWrite <= 1'b0;
      imAddr <= 32'h00000000;
      imWdata <= 32'h00000000;
    end
    else if (ce)
    begin
      tgtPrev_q <= pinSync[5];
      if (tgtFall)
      begin
        tgtRetry <= 1'b0;
        tgtAck <= 1'b0;
      end
      if (tgtRise && win2Hit)
      begin
        case (tgtState_q)
          T_IDLE:
          begin
            heldAddr_q <= tgtAddr;
            imAddr <= tgtAddr;
            imReq <= 1'b1;
            imWrite <= tgtWrite;
            if (tgtWrite)
            begin
              imWdata <= tgtWdata;
              tgtAck <= 1'b1;
              tgtState_q <= T_WRPOST;
            end
            else
            begin
              tgtRetry <= 1'b1;
              tgtState_q <= T_RDPEND;
            end
          end
          T_RDREADY:
          begin
            if (!tgtWrite && tgtAddr == heldAddr_q)
            begin
              tgtAck <= 1'b1;
              tgtState_q <= T_IDLE;
            end
            else
              tgtRetry <= 1'b1;
          end
          default:
            tgtRetry <= 1'b1;
        endcase
      end
      if (imReq && imAck)
      begin
        imReq <= 1'b0;
        if (tgtState_q == T_RDPEND)
        begin
          tgtRdata <= imRdata;
          tgtState_q <= T_RDREADY;
        end
        else
          tgtState_q <= T_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal slave path onto pci
  reg pmRead_q;
  reg [7:0] retryCnt_q;
  wire limitHit = (retryLimit_q != 8'h00) && (retryCnt_q + 8'h01 == retryLimit_q);
  assign retryFail = ce & retryRise & pmStart & limitHit;

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      donePrev_q <= 1'b0;
      retryPrev_q <= 1'b0;
      pmPend_q <= 1'b0;
      pmRead_q <= 1'b0;
      retryCnt_q <= 8'h00;
      failAddr_q <= 32'h00000000;
      isRdy <= 1'b0;
      isRdata <= 32'h00000000;
      pmStart <= 1'b0;
      pmWrite <= 1'b0;
      pmAddr <= 32'h00000000;
      pmWdata <= 32'h00000000;
    end
    else if (ce)
    begin
      donePrev_q <= pinSync[6];
      retryPrev_q <= pinSync[7];
      isRdy <= 1'b0;
      if (isReq && !pmPend_q && !isRdy)
      begin
        pmPend_q <= 1'b1;
        pmAddr <= isAddr;
        pmWrite <= isWrite;
        pmWdata <= isWdata;
        pmRead_q <= ~isWrite;
        retryCnt_q <= 8'h00;
        isRdy <= isWrite;
      end
      if (pmPend_q && bridgeGrant && !pmStart && !frameOn)
        pmStart <= 1'b1;
      if (pmStart && doneRise)
      begin
        pmStart <= 1'b0;
        pmPend_q <= 1'b0;
        if (pmRead_q)
        begin
          isRdata <= pmRdata;
          isRdy <= 1'b1;
        end
      end
      else if (pmStart && retryRise)
      begin
        pmStart <= 1'b0;
        retryCnt_q <= retryCnt_q + 8'h01;
        if (limitHit)
        begin
          // the waiting internal read is released with dummy data
          pmPend_q <= 1'b0;
          failAddr_q <= pmAddr;
          isRdata <= 32'h00000000;
          isRdy <= pmRead_q;
        end
      end
    end
  end
endmodule

// File: sim/pcihb_bridge_assertions.sv
// checker for the bridge's grant, target, internal bus and pci master ports
`timescale 1ns/100ps
module pcihb_bridge_chk (
  input wire mclk,
  input wire rstn,
  input wire pciClk,
  input wire [2:0] extGrantN,
  input wire bridgeGrant,
  input wire frameN,
  input wire tgtWrite,
  input wire tgtRetry,
  input wire tgtAck,
  input wire imReq,
  input wire imWrite,
  input wire [31:0] imAddr,
  input wire imAck,
  input wire isRdy,
  input wire pmStart,
  input wire [31:0] pmAddr,
  input wire pmDone,
  input wire pmRetry
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  logic pciPrev_q;
  logic [4:0] frmCnt_q;
  logic [3:0] grantPrev_q;
  ////////////////////////////////////////////////////////////////////////////////
  // raw pci edges are counted; the bridge sees them through a synchroniser, hence slack
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pciPrev_q <= 1'h0;
      frmCnt_q <= 5'h0;
      grantPrev_q <= 4'hF;
    end
    else
    begin
      pciPrev_q <= pciClk;
      grantPrev_q <= {bridgeGrant, extGrantN};
      if (grantPrev_q != {bridgeGrant, extGrantN} || !frameN || bridgeGrant)
        frmCnt_q <= 5'h0;
      else if (pciClk && !pciPrev_q)
        frmCnt_q <= frmCnt_q + 5'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_grant_onehot: assert property ($onehot({~extGrantN, bridgeGrant}))
    else $error("grant is not one-hot");
  a_frame_timer: assert property (frmCnt_q <= 5'h12)
    else $error("external grant held too long without frame");
  a_answer_excl: assert property (!(tgtRetry && tgtAck))
    else $error("target retry and ack together");
  a_read_retry: assert property ($rose(imReq) && !imWrite |-> tgtRetry)
    else $error("internal read started without target retry");
  a_write_post: assert property ($rose(imReq) && imWrite |-> tgtAck)
    else $error("internal write started without target ack");
  a_read_done: assert property ($rose(tgtAck) && !tgtWrite |-> !imReq)
    else $error("read data given while internal read pending");
  a_im_hold: assert property (imReq && !imAck |=>
    imReq && $stable(imAddr) && $stable(imWrite)) else $error("internal request dropped");
  a_ready_pulse: assert property (isRdy |=> !isRdy)
    else $error("slave ready longer than one cycle");
  a_pm_granted: assert property ($rose(pmStart) |-> $past(bridgeGrant))
    else $error("pci operation started without grant");
  a_pm_hold: assert property (pmStart && !pmDone && !pmRetry |=>
    pmStart && $stable(pmAddr)) else $error("pci operation dropped early");
endmodule
bind pcihb_bridge pcihb_bridge_chk u_chk (.*);

// File: sim/pcihb_far_model.sv
// far-side model: internal bus slave and pci target answering the bridge
`timescale 1ns/100ps
module pcihb_far_model (
  input wire mclk,
  input wire rstn,
  input wire imReq,
  input wire imWrite,
  input wire [31:0] imWdata,
  output logic imAck,
  output wire [31:0] imRdata,
  input wire pmStart,
  input wire pmWrite,
  input wire [31:0] pmWdata,
  output logic pmDone,
  output logic pmRetry,
  output wire [31:0] pmRdata,
  input wire [3:0] farDelay,
  input wire farRetry,
  input wire [31:0] farRdata
);
  logic [3:0] waitCnt_q;
  logic [31:0] wrData_q, toggle_q;
  logic [7:0] tries_q;
  // released data lines move every cycle so a stale value never passes
  assign imRdata = imAck ? farRdata : toggle_q;
  assign pmRdata = pmDone ? farRdata : ~toggle_q;
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      {imAck, pmDone, pmRetry, waitCnt_q, wrData_q, toggle_q, tries_q} <= '0;
    else
    begin
      toggle_q <= toggle_q + 32'h1;
      imAck <= 1'h0;
      if (!pmStart)
        {pmDone, pmRetry} <= 2'h0;
      if ((imReq && !imAck) || (pmStart && !pmDone && !pmRetry))
        waitCnt_q <= waitCnt_q + 4'h1;
      if (imReq && !imAck && waitCnt_q >= farDelay)
      begin
        imAck <= 1'h1;
        waitCnt_q <= 4'h0;
        if (imWrite) wrData_q <= imWdata;
      end
      else if (pmStart && !pmDone && !pmRetry && waitCnt_q >= farDelay)
      begin
        waitCnt_q <= 4'h0;
        // a commanded retry lets the bench drive the bridge into its limit
        if (farRetry) {pmRetry, tries_q} <= {1'h1, tries_q + 8'h1};
        else {pmDone, wrData_q} <= {1'h1, pmWrite ? pmWdata : wrData_q};
      end
    end
  end
endmodule

// File: sim/pcihb_bridge_tb.sv
// self-checking bench for the pci host bridge arbiter block
`timescale 1ns/100ps
module pcihb_bridge_tb;
  logic mclk = 1'h0, rstn = 1'h0, ce = 1'h1, pciClk = 1'h0, frameN = 1'h1, ack, rty;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, isReq = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, tgtValid = 1'h0, tgtWrite = 1'h0;
  logic isWrite = 1'h0, farRetry = 1'h0;
  logic [1:0] rsp;
  logic [2:0] extRequestN = 3'h7;
  logic [3:0] s_axi_wstrb = 4'hF, farDelay = 4'h2;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, q;
  logic [31:0] tgtAddr = 32'h0, tgtWdata = 32'h0, isAddr = 32'h0, isWdata = 32'h0;
  logic [31:0] farRdata = 32'hCAFE0123;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bridgeGrant;
  wire tgtRetry, tgtAck, imReq, imWrite, imAck, isRdy, pmStart, pmWrite, pmDone, pmRetry;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [2:0] extGrantN;
  wire [31:0] s_axi_rdata, tgtRdata, imAddr, imWdata, imRdata, isRdata, pmAddr, pmWdata;
  wire [31:0] pmRdata;
  int checks = 0, error_cnt = 0, n;
  pcihb_bridge u_dut (.*);
  pcihb_far_model u_far (.*);
  always #50 mclk = ~mclk;
  initial
  begin
    #137;
    forever #400 pciClk = ~pciClk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, e);
    checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error at %0t ns: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, d);
    @(posedge mclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    {rsp, q} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'h0;
  endtask
  task automatic tgt(input logic w, input logic [31:0] a, d);
    @(posedge mclk);
    {tgtWrite, tgtAddr, tgtWdata, tgtValid} <= {w, a, d, 1'h1};
    for (int i = 0; i < 40 && !tgtRetry && !tgtAck; i++) @(posedge mclk);
    {rty, ack, q} = {tgtRetry, tgtAck, tgtRdata};
    {tgtValid, tgtAddr, tgtWdata} <= {1'h0, ~a, ~d};
    for (int i = 0; i < 40 && (tgtRetry || tgtAck); i++) @(posedge mclk);
  endtask
  task automatic isx(input logic w, input logic [31:0] a, d);
    @(posedge mclk);
    {isWrite, isAddr, isWdata, isReq} <= {w, a, d, 1'h1};
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (!isRdy && n < 400);
    q = isRdata;
    {isReq, isAddr, isWdata} <= {1'h0, ~a, ~d};
  endtask
  task automatic waitPm;
    for (int i = 0; i < 400 && !pmStart; i++) @(posedge mclk);
    for (int i = 0; i < 400 && pmStart; i++) @(posedge mclk);
  endtask
  task automatic waitIm;
    for (int i = 0; i < 99 && imReq; i++) @(posedge mclk);
  endtask
  // pin inputs reach the arbiter through a synchroniser, so allow a few mclk after the edge
  task automatic pci(input int k);
    repeat (k) @(posedge pciClk);
    repeat (4) @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic regs;
    rd(32'h0F000D3C);
    chk(q, 32'h00000100);
    rd(32'h0F000D40);
    chk(q, 32'h0);
    wr(32'h0F000D3C, 32'hFFFFFFFF);
    rd(32'h0F000D3C);
    chk(q, 32'h000001FF);
    wr(32'h0F000D40, 32'hFFFFFFFF);
    rd(32'h0F000D40);
    chk(q, 32'h0700FF00);
    wr(32'h0F000D44, 32'h0);
    chk(32'(rsp), 32'h2);
    rd(32'h0F000D44);
    chk(32'(rsp), 32'h2);
    chk(q, 32'h0);
  endtask
  task automatic win;
    wr(32'h0F000D60, 32'h0000000F);
    wr(32'h0F000D18, 32'hFFFFFFFF);
    rd(32'h0F000D18);
    chk(q, 32'hF1E00008);
    wr(32'h0F000D60, 32'h0000007F);
    wr(32'h0F000D18, 32'h20000000);
    rd(32'h0F000D18);
    chk(q, 32'h20000008);
  endtask
  task automatic tgtT;
    farDelay <= 4'hF;
    tgt(1'h0, 32'h20000040, 32'h0);
    chk(32'(ack), 32'h0);
    chk(32'(rty), 32'h1);
    chk(32'(imReq), 32'h1);
    chk(imAddr, 32'h20000040);
    tgt(1'h0, 32'h20000080, 32'h0);
    chk(32'(ack), 32'h0);
    chk(32'(rty), 32'h1);
    waitIm;
    tgt(1'h0, 32'h20000040, 32'h0);
    chk(q, farRdata);
    chk(32'(ack), 32'h1);
    farDelay <= 4'h2;
    tgt(1'h1, 32'h20000100, 32'h5A5A1234);
    chk(32'(ack), 32'h1);
    waitIm;
    chk(u_far.wrData_q, 32'h5A5A1234);
  endtask
  task automatic intT;
    isx(1'h1, 32'h40001000, 32'h0BADF00D);
    chk(32'(n < 4), 32'h1);
    waitPm;
    chk(u_far.wrData_q, 32'h0BADF00D);
    farDelay <= 4'h8;
    isx(1'h0, 32'h40001004, 32'h0);
    chk(q, farRdata);
    chk(32'(n > 8), 32'h1);
  endtask
  task automatic limT;
    wr(32'h0F000D40, 32'h00000300);
    farRetry <= 1'h1;
    isx(1'h1, 32'h40002000, 32'h11);
    q = 32'h0;
    for (int i = 0; i < 40 && !q[0]; i++) rd(32'h0F000D64);
    chk(q & 32'h1, 32'h1);
    chk(32'(u_far.tries_q), 32'h3);
    chk(u_far.wrData_q, 32'h0BADF00D);
    rd(32'h0F000D68);
    chk(q, 32'h40002000);
    farRetry <= 1'h0;
    wr(32'h0F000D64, 32'h1);
    rd(32'h0F000D64);
    chk(q & 32'h1, 32'h0);
  endtask
  task automatic arbT;
    wr(32'h0F000D40, 32'h0);
    extRequestN <= 3'h5;
    for (n = 0; n < 99 && extGrantN !== 3'h5; n++) @(posedge mclk);
    chk(32'(bridgeGrant), 32'h0);
    for (n = 0; n < 300 && extGrantN[1] === 1'h0; n++) @(posedge mclk);
    chk(32'(n >= 120 && n <= 136), 32'h1);
    chk(32'(bridgeGrant), 32'h1);
    extRequestN <= 3'h7;
    wr(32'h0F000D40, 32'h05000000);
    extRequestN <= 3'h3;
    pci(3);
    chk(32'(extGrantN), 32'h3);
    extRequestN <= 3'h2;
    pci(2);
    chk(32'(extGrantN), 32'h6);
    extRequestN <= 3'h7;
    wr(32'h0F000D40, 32'h07000000);
    extRequestN <= 3'h3;
    pci(3);
    extRequestN <= 3'h2;
    pci(2);
    chk(32'(extGrantN), 32'h3);
    {extRequestN, frameN} <= {3'h3, 1'h0};
    pci(2);
    {extRequestN, frameN} <= {3'h7, 1'h1};
    pci(3);
    chk(32'(extGrantN), 32'h3);
    wr(32'h0F000D40, 32'h06000000);
    extRequestN <= 3'h5;
    pci(3);
    farDelay <= 4'hF;
    isx(1'h1, 32'h40003000, 32'h22);
    // look before the posted write completes and the bridge lets go of the bus
    pci(2);
    chk(32'(bridgeGrant), 32'h1);
    waitPm;
    extRequestN <= 3'h7;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #1000000;
    error_cnt++;
    stop_test;
  end
  initial
  begin
    repeat (5) @(posedge mclk);
    rstn <= 1'h1;
    regs;
    win;
    tgtT;
    intT;
    limT;
    arbT;
    stop_test;
  end
endmodule
